// ### core/clcse_pkg.sv
// Package for closed-loop current scaling and back-EMF compensation.
// Assumes register indices are word indices on a 32-bit APB bus.
package clcse_pkg;

    // -------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_CURRENT_CONFIG   = 8'h05;
    localparam logic [7:0] IDX_SCALE_VALUES     = 8'h06;
    localparam logic [7:0] IDX_ENC_IN_CONFIG    = 8'h07;
    localparam logic [7:0] IDX_UPSCALE_DELAY    = 8'h18;
    localparam logic [7:0] IDX_DNSCALE_DELAY    = 8'h19;
    localparam logic [7:0] IDX_MAX_LOAD_ANGLE   = 8'h1c;
    localparam logic [7:0] IDX_MAX_LEAD_ANGLE   = 8'h1d;
    localparam logic [7:0] IDX_EMF_MIN_VEL      = 8'h60;
    localparam logic [7:0] IDX_EMF_VEL_RANGE    = 8'h61;
    localparam logic [7:0] IDX_ENC_VEL          = 8'h65;
    localparam logic [7:0] IDX_ENC_VEL_FILT     = 8'h66;

    // -------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------
    localparam int          CC_OPEN_OPTS_W      = 5;
    localparam int          CC_CL_SCALE_EN_BIT  = 7;
    localparam int          EIC_EMF_EN_BIT      = 0;
    localparam int          ANGLE_W             = 10;
    localparam int          LEAD_W              = 9;
    localparam logic [31:0] RST_ZERO            = 32'h0000_0000;
    localparam logic [31:0] RST_MAX_LOAD_ANGLE  = 32'h0000_00ff;
    localparam logic [31:0] RST_MAX_LEAD_ANGLE  = 32'h0000_00ff;
    localparam logic [7:0]  SCALE_FULL          = 8'hff;

    // Layout of the shared scaling register
    typedef struct packed {
        logic [7:0] topByte;
        logic [7:0] startupThreshold;
        logic [7:0] currentMax;
        logic [7:0] currentMin;
    } clcse_scale_type;

    typedef enum logic [1:0] {
        HOLD,
        STEP_UP,
        STEP_DOWN
    } clcse_dir_type;

endpackage

// ### core/clcse_core.sv
// Closed-loop current scale selection, scale stepping and back-EMF
// load angle compensation, with an APB register slave.
// Assumes deviation, velocities and commutation angle come from logic on ref_clk.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - Closed-loop scale enable bit in current_config turns closed-loop scaling on.
// R2 - While closed-loop scaling is on, all open-loop scaling options read inactive.
// R3 - Minimum, maximum and start-up threshold live in current_scale_values fields.
// R4 - Software clears the top byte of current_scale_values before enabling.
// R5 - Scale is minimum, then linear ramp up to max_lead_angle, then maximum.
// R6 - Higher target: raise active scale one step per upscale delay cycles.
// R7 - Upscale delay zero: jump straight to the higher target.
// R8 - Lower target: lower active scale one step per downscale delay cycles.
// R9 - Downscale delay zero: jump straight to the lower target.
// R10 - With compensation on, add signed gamma to the commutation angle.
// R11 - Gamma thresholds use the filtered encoder velocity.
// R12 - Gamma zero, then linear ramp, then max_load_angle above the range.
// R13 - max_load_angle resets to 255, meaning ninety degrees.
// R14 - Minimum EMF velocity and EMF range each sit in a writable register.
// R15 - EMF enable bit in encoder_input_config gates the compensation.
// R16 - Software keeps lead plus load angle below 511 microsteps.
// R17 - Interpolations truncate and are recomputed every clock cycle.
module clcse_core
    import clcse_pkg::*;
#(
    parameter int DELAY_W = 32
)(
    input  wire logic                 ref_clk,            // System clock
    input  wire logic                 sys_rst,            // Synchronous reset
    input  wire logic                 psel,               // APB select
    input  wire logic                 penable,            // APB access phase
    input  wire logic                 pwrite,             // APB write
    input  wire logic [11:0]          paddr,              // APB byte address
    input  wire logic [31:0]          pwdata,             // APB write data
    output logic      [31:0]          prdata,             // APB read data
    output logic                      pready,             // APB ready
    output logic                      pslverr,            // APB error
    input  wire logic signed [31:0]   positionDeviation,  // Encoder position deviation
    input  wire logic signed [31:0]   encoderVelocity,    // Raw encoder velocity
    input  wire logic signed [31:0]   encoderVelocityFiltered, // Filtered velocity
    input  wire logic [ANGLE_W-1:0]   commutationAngle,   // Microstep table angle
    output logic [7:0]                activeScaleFactor,  // Scale to the driver
    output logic [CC_OPEN_OPTS_W-1:0] openLoopOptions,    // Effective open-loop options
    output logic [7:0]                loadAngle,          // Current gamma
    output logic [ANGLE_W-1:0]        compensatedAngle    // Angle plus gamma
);
    import clcse_pkg::*;

    if (DELAY_W < 1 || DELAY_W > 32)
    begin
        $error("DELAY_W must be 1 to 32");
    end

    // -------------------------------------------------------------------
    // Register file
    // -------------------------------------------------------------------
    logic [31:0] currentConfig_r, currentConfig_nxt;
    logic [31:0] scaleValues_r, scaleValues_nxt;
    logic [31:0] encInConfig_r, encInConfig_nxt;
    logic [31:0] upDelay_r, upDelay_nxt;
    logic [31:0] dnDelay_r, dnDelay_nxt;
    logic [31:0] maxLoadAngle_r, maxLoadAngle_nxt;
    logic [31:0] maxLeadAngle_r, maxLeadAngle_nxt;
    logic [31:0] emfMinVel_r, emfMinVel_nxt;
    logic [31:0] emfVelRange_r, emfVelRange_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;

    logic        access;
    logic        mapped;
    logic [7:0]  index;
    logic [31:0] readMux;

    assign access = psel & penable;
    assign index  = paddr[9:2];

    always_comb
    begin
        mapped  = 1'b1;
        readMux = RST_ZERO;
        case (index)
            IDX_CURRENT_CONFIG: readMux = currentConfig_r;
            IDX_SCALE_VALUES:   readMux = scaleValues_r;
            IDX_ENC_IN_CONFIG:  readMux = encInConfig_r;
            IDX_UPSCALE_DELAY:  readMux = upDelay_r;
            IDX_DNSCALE_DELAY:  readMux = dnDelay_r;
            IDX_MAX_LOAD_ANGLE: readMux = maxLoadAngle_r;
            IDX_MAX_LEAD_ANGLE: readMux = maxLeadAngle_r;
            IDX_EMF_MIN_VEL:    readMux = emfMinVel_r;
            IDX_EMF_VEL_RANGE:  readMux = emfVelRange_r;
            IDX_ENC_VEL:        readMux = encoderVelocity;
            IDX_ENC_VEL_FILT:   readMux = encoderVelocityFiltered;
            default:            mapped  = 1'b0;
        endcase
        if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00)
            mapped = 1'b0;
    end

    always_comb
    begin
        currentConfig_nxt = currentConfig_r;
        scaleValues_nxt   = scaleValues_r;
        encInConfig_nxt   = encInConfig_r;
        upDelay_nxt       = upDelay_r;
        dnDelay_nxt       = dnDelay_r;
        maxLoadAngle_nxt  = maxLoadAngle_r;
        maxLeadAngle_nxt  = maxLeadAngle_r;
        emfMinVel_nxt     = emfMinVel_r;
        emfVelRange_nxt   = emfVelRange_r;
        // Answer on the second access cycle
        pready_nxt        = access & ~pready_r;
        prdata_nxt        = prdata_r;
        pslverr_nxt       = 1'b0;
        if (access & ~pready_r)
        begin
            prdata_nxt  = (mapped && !pwrite) ? readMux : RST_ZERO;
            pslverr_nxt = ~mapped;
        end
        if (access & pready_r & pwrite & mapped)
        begin
            case (index)
                IDX_CURRENT_CONFIG: currentConfig_nxt = pwdata; // R1
                IDX_SCALE_VALUES:   scaleValues_nxt   = pwdata; // R3
                IDX_ENC_IN_CONFIG:  encInConfig_nxt   = pwdata; // R15
                IDX_UPSCALE_DELAY:  upDelay_nxt       = pwdata;
                IDX_DNSCALE_DELAY:  dnDelay_nxt       = pwdata;
                IDX_MAX_LOAD_ANGLE: maxLoadAngle_nxt  = {24'h0, pwdata[7:0]};
                IDX_MAX_LEAD_ANGLE: maxLeadAngle_nxt  = {23'h0, pwdata[LEAD_W-1:0]};
                IDX_EMF_MIN_VEL:    emfMinVel_nxt     = pwdata; // R14
                IDX_EMF_VEL_RANGE:  emfVelRange_nxt   = pwdata; // R14
                default:            currentConfig_nxt = currentConfig_r;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            currentConfig_r <= RST_ZERO;
            scaleValues_r   <= RST_ZERO;
            encInConfig_r   <= RST_ZERO;
            upDelay_r       <= RST_ZERO;
            dnDelay_r       <= RST_ZERO;
            maxLoadAngle_r  <= RST_MAX_LOAD_ANGLE; // R13
            maxLeadAngle_r  <= RST_MAX_LEAD_ANGLE;
            emfMinVel_r     <= RST_ZERO;
            emfVelRange_r   <= RST_ZERO;
            prdata_r        <= RST_ZERO;
            pready_r        <= 1'b0;
            pslverr_r       <= 1'b0;
        end
        else
        begin
            currentConfig_r <= currentConfig_nxt;
            scaleValues_r   <= scaleValues_nxt;
            encInConfig_r   <= encInConfig_nxt;
            upDelay_r       <= upDelay_nxt;
            dnDelay_r       <= dnDelay_nxt;
            maxLoadAngle_r  <= maxLoadAngle_nxt;
            maxLeadAngle_r  <= maxLeadAngle_nxt;
            emfMinVel_r     <= emfMinVel_nxt;
            emfVelRange_r   <= emfVelRange_nxt;
            prdata_r        <= prdata_nxt;
            pready_r        <= pready_nxt;
            pslverr_r       <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // -------------------------------------------------------------------
    // Scale target from position deviation
    // -------------------------------------------------------------------
    clcse_scale_type sv;
    logic            clScaleEn;
    logic [31:0]     absDev;
    logic [31:0]     devOver;
    logic [31:0]     devSpan;
    logic [39:0]     scaleProd;
    logic [39:0]     scaleQuot;
    logic [8:0]      scaleSum;
    logic [7:0]      scaleRise;
    logic [7:0]      scaleTarget;

    assign sv        = clcse_scale_type'(scaleValues_r);
    assign clScaleEn = currentConfig_r[CC_CL_SCALE_EN_BIT];
    assign absDev    = positionDeviation[31] ? 32'(-positionDeviation)
                                             : 32'(positionDeviation);

    always_comb
    begin
        devOver     = absDev - {24'h0, sv.startupThreshold};
        devSpan     = maxLeadAngle_r - {24'h0, sv.startupThreshold};
        scaleRise   = (sv.currentMax > sv.currentMin) ? sv.currentMax - sv.currentMin : 8'h00;
        scaleProd   = {8'h0, devOver} * {32'h0, scaleRise};
        scaleQuot   = (devSpan != 32'h0) ? scaleProd / {8'h0, devSpan} : {32'h0, scaleRise}; // R17
        scaleSum    = {1'b0, sv.currentMin} + ((scaleQuot > {32'h0, scaleRise})
                      ? {1'b0, scaleRise} : {1'b0, scaleQuot[7:0]});
        if (!clScaleEn)
            scaleTarget = SCALE_FULL;
        else if (absDev <= {24'h0, sv.startupThreshold})
            scaleTarget = sv.currentMin;                    // R5
        else if (absDev <= maxLeadAngle_r)
            scaleTarget = scaleSum[7:0];                    // R5
        else
            scaleTarget = sv.currentMax;                    // R5
    end

    // -------------------------------------------------------------------
    // Stepping of the active scale factor
    // -------------------------------------------------------------------
    clcse_dir_type      dir;
    logic [7:0]         scale_r, scale_nxt;
    logic [DELAY_W-1:0] wait_r, wait_nxt;
    logic [DELAY_W-1:0] upLim;
    logic [DELAY_W-1:0] dnLim;

    assign upLim = upDelay_r[DELAY_W-1:0];
    assign dnLim = dnDelay_r[DELAY_W-1:0];

    always_comb
    begin
        if (scaleTarget > scale_r)
            dir = STEP_UP;
        else if (scaleTarget < scale_r)
            dir = STEP_DOWN;
        else
            dir = HOLD;
        scale_nxt = scale_r;
        wait_nxt  = '0;
        case (dir)
            STEP_UP:
            begin
                if (upLim == '0)
                    scale_nxt = scaleTarget;                // R7
                else if (wait_r + 1'b1 >= upLim)
                    scale_nxt = scale_r + 8'h01;            // R6
                else
                    wait_nxt = wait_r + 1'b1;               // R6
            end
            STEP_DOWN:
            begin
                if (dnLim == '0)
                    scale_nxt = scaleTarget;                // R9
                else if (wait_r + 1'b1 >= dnLim)
                    scale_nxt = scale_r - 8'h01;            // R8
                else
                    wait_nxt = wait_r + 1'b1;               // R8
            end
            default:
                wait_nxt = '0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            scale_r <= SCALE_FULL;
            wait_r  <= '0;
        end
        else
        begin
            scale_r <= scale_nxt;
            wait_r  <= wait_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Load angle from filtered velocity
    // -------------------------------------------------------------------
    logic        emfEn;
    logic [31:0] absVel;
    logic [32:0] velTop;
    logic [31:0] velOver;
    logic [39:0] gammaProd;
    logic [39:0] gammaQuot;
    logic [7:0]  gamma;
    logic [7:0]  maxGamma;

    assign emfEn    = encInConfig_r[EIC_EMF_EN_BIT];
    assign maxGamma = maxLoadAngle_r[7:0];
    assign absVel   = encoderVelocityFiltered[31] ? 32'(-encoderVelocityFiltered)   // R11
                                                  : 32'(encoderVelocityFiltered);

    always_comb
    begin
        velTop    = {1'b0, emfMinVel_r} + {1'b0, emfVelRange_r};
        velOver   = absVel - emfMinVel_r;
        gammaProd = {8'h0, velOver} * {32'h0, maxGamma};
        gammaQuot = (emfVelRange_r != 32'h0) ? gammaProd / {8'h0, emfVelRange_r}  // R17
                                             : {32'h0, maxGamma};
        if (!emfEn || absVel <= emfMinVel_r)
            gamma = 8'h00;                                  // R12
        else if ({1'b0, absVel} <= velTop)
            gamma = (gammaQuot > {32'h0, maxGamma}) ? maxGamma : gammaQuot[7:0]; // R12
        else
            gamma = maxGamma;                               // R12
    end

    // -------------------------------------------------------------------
    // Output registers
    // -------------------------------------------------------------------
    logic [ANGLE_W-1:0]        angle_r, angle_nxt;
    logic [7:0]                gamma_r;
    logic [CC_OPEN_OPTS_W-1:0] openOpts_r, openOpts_nxt;

    always_comb
    begin
        // Gamma follows the direction of motion
        if (encoderVelocityFiltered[31])
            angle_nxt = commutationAngle - ANGLE_W'(gamma); // R10
        else
            angle_nxt = commutationAngle + ANGLE_W'(gamma); // R10
        openOpts_nxt = clScaleEn ? '0 : currentConfig_r[CC_OPEN_OPTS_W-1:0]; // R2
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            angle_r    <= '0;
            gamma_r    <= 8'h00;
            openOpts_r <= '0;
        end
        else
        begin
            angle_r    <= angle_nxt;
            gamma_r    <= gamma;
            openOpts_r <= openOpts_nxt;
        end
    end

    assign activeScaleFactor = scale_r;
    assign openLoopOptions   = openOpts_r;
    assign loadAngle         = gamma_r;
    assign compensatedAngle  = angle_r;

endmodule

`default_nettype wire

// ### verification/clcse_checker.sv
// Checker for the scale and load angle block, bound to clcse_core.
// Assumes register writes land at the edge that samples pready.
`timescale 1ns/1ps
`default_nettype none
module clcse_checker (
    input wire logic                                 ref_clk,                 // Clock
    input wire logic                                 sys_rst,                 // Reset
    input wire logic                                 psel,                    // APB select
    input wire logic                                 penable,                 // APB enable
    input wire logic                                 pwrite,                  // APB write
    input wire logic        [11:0]                   paddr,                   // APB address
    input wire logic        [31:0]                   pwdata,                  // APB data
    input wire logic                                 pready,                  // APB ready
    input wire logic                                 pslverr,                 // APB error
    input wire logic signed [31:0]                   encoderVelocityFiltered, // Velocity
    input wire logic        [clcse_pkg::ANGLE_W-1:0] commutationAngle,        // Angle in
    input wire logic        [7:0]                    activeScaleFactor,       // Scale
    input wire logic        [clcse_pkg::CC_OPEN_OPTS_W-1:0] openLoopOptions,  // Options
    input wire logic        [7:0]                    loadAngle,               // Gamma
    input wire logic        [clcse_pkg::ANGLE_W-1:0] compensatedAngle         // Angle out
);
    import clcse_pkg::*;
    // ------------------------------------------------------------
    // Register shadow and step spacing
    // ------------------------------------------------------------
    logic [31:0] shadow [256];
    logic [7:0]  prevScale;
    logic [31:0] gap;
    logic [31:0] vmag;
    logic [32:0] vtop;
    assign vmag = encoderVelocityFiltered[31] ? -encoderVelocityFiltered : encoderVelocityFiltered;
    assign vtop = {1'b0, shadow[IDX_EMF_MIN_VEL]} + {1'b0, shadow[IDX_EMF_VEL_RANGE]};
    always_ff @(posedge ref_clk)
    begin
        prevScale <= activeScaleFactor;
        gap <= (sys_rst || activeScaleFactor != prevScale) ? 32'h1 : gap + 32'h1;
        if (sys_rst)
            foreach (shadow[i]) shadow[i] <= (i == IDX_MAX_LOAD_ANGLE) ? RST_MAX_LOAD_ANGLE : '0;
        else if (psel && penable && pready && pwrite && !pslverr)
            shadow[paddr[9:2]] <= pwdata;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_ready_lat; psel && !penable |-> ##2 pready; endproperty
    a_ready_lat: assert property (p_ready_lat) else $error("late ready");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
    property p_open_off; openLoopOptions == ($past(shadow[IDX_CURRENT_CONFIG][CC_CL_SCALE_EN_BIT])
        ? 5'h00 : $past(shadow[IDX_CURRENT_CONFIG][CC_OPEN_OPTS_W-1:0])); endproperty
    a_open_off: assert property (p_open_off) else $error("open options wrong");
    property p_step_up; shadow[IDX_UPSCALE_DELAY] != 0 && activeScaleFactor > prevScale
        |-> activeScaleFactor == prevScale + 8'h01 && gap >= shadow[IDX_UPSCALE_DELAY]; endproperty
    a_step_up: assert property (p_step_up) else $error("bad up step");
    property p_step_dn; shadow[IDX_DNSCALE_DELAY] != 0 && activeScaleFactor < prevScale
        |-> activeScaleFactor == prevScale - 8'h01 && gap >= shadow[IDX_DNSCALE_DELAY]; endproperty
    a_step_dn: assert property (p_step_dn) else $error("bad down step");
    property p_angle; !$past(sys_rst) |-> compensatedAngle == ($past(encoderVelocityFiltered[31])
        ? $past(commutationAngle) - {2'b00, loadAngle}
        : $past(commutationAngle) + {2'b00, loadAngle}); endproperty
    a_angle: assert property (p_angle) else $error("angle sum wrong");
    property p_gamma_off; !$past(sys_rst) && (!$past(shadow[IDX_ENC_IN_CONFIG][EIC_EMF_EN_BIT])
        || $past(vmag <= shadow[IDX_EMF_MIN_VEL])) |-> loadAngle == 8'h00; endproperty
    a_gamma_off: assert property (p_gamma_off) else $error("gamma not zero");
    property p_gamma_max; !$past(sys_rst) && $past(shadow[IDX_ENC_IN_CONFIG][EIC_EMF_EN_BIT])
        && $past({1'b0, vmag} > vtop) |-> loadAngle == $past(shadow[IDX_MAX_LOAD_ANGLE][7:0]);
    endproperty
    a_gamma_max: assert property (p_gamma_max) else $error("gamma not max");
    c_up: cover property (activeScaleFactor == prevScale + 8'h01);
    c_dn: cover property (activeScaleFactor == prevScale - 8'h01);
    c_jump: cover property (activeScaleFactor > prevScale + 8'h01);
endmodule
`default_nettype wire

// ### verification/clcse_driver_model.sv
// Model of the stepper driver that takes the active scale.
// Assumes the scale arrives on ref_clk with no handshake.
`timescale 1ns/1ps
`default_nettype none
module clcse_driver_model (
    input  wire logic        ref_clk,   // Clock
    input  wire logic        sys_rst,   // Reset
    input  wire logic [7:0]  scale,     // Scale in
    output logic      [15:0] stepCount  // Changes seen
);
    logic [7:0] lastScale;
    always_ff @(posedge ref_clk)
    begin
        lastScale <= scale;
        stepCount <= sys_rst ? 16'h0000 : stepCount + {15'h0000, scale != lastScale};
    end
endmodule
`default_nettype wire

// ### verification/tb_closed_loop_current_scale_emf.sv
// Testbench for the scale and load angle block.
// Assumes APB answers two cycles after setup and inputs on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module tb_closed_loop_current_scale_emf;
    import clcse_pkg::*;
    localparam int VMIN = 100;
    localparam int VADD = 200;
    localparam int GMAX = 64;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic [31:0] rdata;
    logic pready;
    logic pslverr;
    logic serr;
    logic signed [31:0] posDev = 0;
    logic signed [31:0] encVel = 32'h0000_1234;
    logic signed [31:0] encVelF = 1000;
    logic [ANGLE_W-1:0] commAngle = 10'h3f0;
    logic [ANGLE_W-1:0] compAngle;
    logic [ANGLE_W-1:0] ea;
    logic [CC_OPEN_OPTS_W-1:0] openOpts;
    logic [7:0] scale;
    logic [7:0] gamma;
    logic [15:0] driverSteps;
    logic [15:0] s0;
    logic [7:0] rstIdx [9] = '{IDX_CURRENT_CONFIG, IDX_SCALE_VALUES, IDX_ENC_IN_CONFIG,
        IDX_UPSCALE_DELAY, IDX_DNSCALE_DELAY, IDX_MAX_LOAD_ANGLE, IDX_MAX_LEAD_ANGLE,
        IDX_EMF_MIN_VEL, IDX_EMF_VEL_RANGE};
    logic [31:0] rstVal [9] = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_MAX_LOAD_ANGLE, RST_MAX_LEAD_ANGLE, RST_ZERO, RST_ZERO};
    int devs [6] = '{0, 16, 17, -48, 76, 77};
    int vels [7] = '{100, -150, 250, 300, -301, 173, 101};
    int err_count = 0;
    int checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    clcse_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .positionDeviation(posDev), .encoderVelocity(encVel),
        .encoderVelocityFiltered(encVelF), .commutationAngle(commAngle),
        .activeScaleFactor(scale), .openLoopOptions(openOpts), .loadAngle(gamma),
        .compensatedAngle(compAngle));
    clcse_driver_model u_drv (.ref_clk(ref_clk), .sys_rst(sys_rst), .scale(scale),
        .stepCount(driverSteps));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, '0);
        check("read data", rdata, exp);
    endtask
    function automatic logic [7:0] expScale(input int d);
        int a;
        a = d < 0 ? -d : d;
        if (a <= 16) return 8'h20;
        if (a > 76) return 8'ha0;
        return 8'(32 + (a - 16) * 128 / 60);
    endfunction
    function automatic logic [7:0] expGamma(input int v);
        int a;
        a = v < 0 ? -v : v;
        if (a <= VMIN) return 8'h00;
        if (a > VMIN + VADD) return 8'(GMAX);
        return 8'((a - VMIN) * GMAX / VADD);
    endfunction
    task automatic ramp(input logic [7:0] target, input int dly);
        logic [7:0] prev;
        int gap;
        int n;
        prev = scale;
        gap = -100000;
        n = 0;
        while (scale !== target && n < 2000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
            gap++;
            if (scale !== prev)
            begin
                check("step", scale, target > prev ? prev + 8'h01 : prev - 8'h01);
                if (gap > 0) check("step gap", gap, dly);
                gap = 0;
                prev = scale;
            end
        end
        check("ramp end", scale, target);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (rstIdx[i]) rd({2'b00, rstIdx[i], 2'b00}, rstVal[i]);
        apb(1'b0, 12'h3fc, '0);
        check("unmapped error", serr, 1'b1);
        check("unmapped data", rdata, 32'h0);
        rd(12'h194, encVel);
        rd(12'h198, encVelF);
        check("gamma disabled", gamma, 8'h00);
        apb(1'b1, 12'h180, VMIN);
        apb(1'b1, 12'h184, VADD);
        apb(1'b1, 12'h070, GMAX);
        rd(12'h180, VMIN);
        rd(12'h184, VADD);
        rd(12'h070, GMAX);
        apb(1'b1, 12'h014, 32'h0000_001f);
        repeat (2) @(posedge ref_clk);
        check("open options", openOpts, 5'h1f);
        apb(1'b1, 12'h018, 32'h0010_a020);
        apb(1'b1, 12'h074, 32'h0000_004c);
        apb(1'b1, 12'h014, 32'h0000_009f);
        repeat (2) @(posedge ref_clk);
        check("open forced off", openOpts, 5'h00);
        foreach (devs[i])
        begin
            @(posedge ref_clk);
            posDev <= devs[i];
            repeat (4) @(posedge ref_clk);
            #1;
            check("scale", scale, expScale(devs[i]));
        end
        apb(1'b1, 12'h060, 32'h4);
        apb(1'b1, 12'h064, 32'h6);
        s0 = driverSteps;
        posDev <= 0;
        ramp(8'h20, 6);
        repeat (2) @(posedge ref_clk);
        check("driver steps", driverSteps - s0, 16'd128);
        @(posedge ref_clk);
        posDev <= 77;
        ramp(8'ha0, 4);
        apb(1'b1, 12'h01c, 32'h1);
        foreach (vels[i])
        begin
            @(posedge ref_clk);
            encVelF <= vels[i];
            commAngle <= commAngle + 10'h0c5;
            repeat (3) @(posedge ref_clk);
            #1;
            ea = vels[i] < 0 ? commAngle - {2'b00, expGamma(vels[i])}
                : commAngle + {2'b00, expGamma(vels[i])};
            check("gamma", gamma, expGamma(vels[i]));
            check("angle", compAngle, ea);
        end
        tally_and_finish();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        tally_and_finish();
    end
endmodule
bind clcse_core clcse_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .encoderVelocityFiltered(encoderVelocityFiltered),
    .commutationAngle(commutationAngle), .activeScaleFactor(activeScaleFactor),
    .openLoopOptions(openLoopOptions), .loadAngle(loadAngle),
    .compensatedAngle(compensatedAngle));
`default_nettype wire
